// [verilog/rf_frame_codec_consts.svh]
// Purpose: constants of the rf frame codec
// Assumes: included by bare name
// Notes: counts in bytes unless stated
`ifndef RF_FRAME_CODEC_CONSTS_SVH
`define RF_FRAME_CODEC_CONSTS_SVH
`define FIFO_DEPTH 512
`define FIFO_AW 9
`define READER_TX_MAX 13'h1FFF
`define CARD_FRAME_MAX 10'h200
`define SOF_BITS 4'h2
`define CRC_INIT 16'h6363
`define CRC_POLY 16'h8408
`endif

// [verilog/rf_frame_codec_pkg.sv]
// Purpose: types of the rf frame codec
// Assumes: nothing
// Notes: modes are per direction
package rf_frame_codec_pkg;
  typedef enum logic [1:0] {MODE_FRAMED, MODE_STREAM, MODE_TRANSPARENT} path_mode_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } byte_bus_t;
  typedef struct packed {
    logic frameDone;
    logic crcError;
    logic parityError;
    logic framingError;
    logic overflow;
    logic lengthError;
  } rx_status_t;
endpackage

// [verilog/rf_frame_codec_fifo.sv]
// Purpose: frame encoder/decoder with shared 512-byte fifo and bypass modes
// Assumes: all inputs synchronous to sys_clk; one bit per cycle on the rf side
// Notes: tx frame: start pattern, bytes each with odd parity, crc16 lsb first, end marker
// Functional notes
// [R1] framed tx adds start, end, crc and parity around fifo bytes.
// [R2] stream tx sends fifo bits unchanged as modulation.
// [R3] transparent tx lets the host data input drive modulation directly.
// [R4] framed rx checks start, end, crc and parity, strips start and parity, and stores the data bytes followed by the crc bytes.
// [R5] stream rx writes digitized subcarrier samples to the fifo.
// [R6] transparent rx routes the subcarrier to the host data output.
// [R7] one 512-byte fifo holds rx or tx data according to direction.
// [R8] reader tx frames reach 8191 bytes via refill, reader rx is unlimited.
// [R9] card emulation frames are limited to 512 bytes.
// [R10] spi and i2c share pins, a select input picks the active one.
// [R11] one mode per direction, changes taken only between frames.
`timescale 1ns/100ps
`include "rf_frame_codec_consts.svh"
module rf_frame_codec_fifo #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = `FIFO_AW
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // configuration
  input wire rf_frame_codec_pkg::path_mode_t txMode,
  input wire rf_frame_codec_pkg::path_mode_t rxMode,
  input wire logic cardEmulation,
  input wire logic dirTx,
  input wire logic i2cSelect,
  input wire logic [12:0] txLength,
  input wire logic txStart,
  // host fifo port and host pins
  input wire rf_frame_codec_pkg::byte_bus_t hostWrite,
  input wire logic hostReadReq,
  input wire logic hostSerialIn,
  output rf_frame_codec_pkg::byte_bus_t hostRead,
  output logic hostSerialOut,
  output logic spiActive,
  output logic i2cActive,
  // rf side
  input wire logic rxBit,
  input wire logic rxBitValid,
  input wire logic rxFrameEnd,
  output logic txMod,
  output logic txBusy,
  // status
  output rf_frame_codec_pkg::rx_status_t rxStatus,
  output logic [AW:0] fifoCount
);
  typedef enum logic [2:0] {T_IDLE, T_SOF, T_DATA, T_PAR, T_CRC, T_EOF} tx_state_t;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = (c >> 1) ^ (((c[0] ^ b) != 1'b0) ? `CRC_POLY : 16'h0000);
  endfunction

  logic [7:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  tx_state_t ts_reg, ts_next;
  rf_frame_codec_pkg::path_mode_t txm_reg, txm_next, rxm_reg, rxm_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bc_reg, bc_next;
  logic [12:0] left_reg, left_next;
  logic [15:0] crc_reg, crc_next, rcrc_reg, rcrc_next;
  logic par_reg, par_next, rpar_reg, rpar_next;
  logic [8:0] rsh_reg, rsh_next;
  logic [3:0] rbc_reg, rbc_next;
  logic [9:0] rlen_reg, rlen_next;
  logic rsof_reg, rsof_next, rin_reg, rin_next;
  logic mod_reg, mod_next, sout_reg, sout_next, spi_reg, i2c_reg, busy_reg;
  rf_frame_codec_pkg::byte_bus_t hr_reg, hr_next;
  rf_frame_codec_pkg::rx_status_t st_reg, st_next;
  logic push, pop, popTx;
  logic [7:0] pushData;

  always_comb begin
    ts_next = ts_reg;
    txm_next = txm_reg;
    rxm_next = rxm_reg;
    sh_next = sh_reg;
    bc_next = bc_reg;
    left_next = left_reg;
    crc_next = crc_reg;
    par_next = par_reg;
    mod_next = 1'b0;
    popTx = 1'b0;
    rsh_next = rsh_reg;
    rbc_next = rbc_reg;
    rlen_next = rlen_reg;
    rsof_next = rsof_reg;
    rin_next = rin_reg;
    rcrc_next = rcrc_reg;
    rpar_next = rpar_reg;
    st_next = st_reg;
    st_next.frameDone = 1'b0;
    push = 1'b0;
    pushData = 8'h00;
    sout_next = 1'b0;
    // each mode latches only while its own direction is outside a frame
    if (ts_reg == T_IDLE && !txStart) begin
      txm_next = txMode; // [R11]
    end
    if (!rin_reg && !rxBitValid) begin
      rxm_next = rxMode; // [R11]
    end
    unique case (ts_reg)
      T_IDLE: begin
        if (txm_reg == rf_frame_codec_pkg::MODE_TRANSPARENT) begin
          mod_next = hostSerialIn; // [R3]
        end else if (txStart && dirTx && txLength != 13'h0000) begin
          left_next = txLength;
          // card emulation frames cannot outgrow the fifo; reader frames refill
          if (cardEmulation && txLength > 13'(`CARD_FRAME_MAX)) begin
            left_next = 13'(`CARD_FRAME_MAX); // [R9]
          end
          crc_next = `CRC_INIT;
          bc_next = 4'h0;
          ts_next = (txm_reg == rf_frame_codec_pkg::MODE_STREAM) ? T_DATA : T_SOF; // [R2]
        end
      end
      T_SOF: begin
        mod_next = 1'b1; // [R1]
        bc_next = bc_reg + 4'h1;
        if (bc_reg == `SOF_BITS - 4'h1) begin
          ts_next = T_DATA;
          bc_next = 4'h0;
        end
      end
      T_DATA: begin
        // starved fifo stalls the frame instead of sending garbage
        if (bc_reg == 4'h0) begin
          if (left_reg == 13'h0000) begin
            ts_next = (txm_reg == rf_frame_codec_pkg::MODE_STREAM) ? T_IDLE : T_CRC;
            bc_next = 4'h0;
          end else if (cnt_reg != '0) begin
            popTx = 1'b1; // [R8]
            sh_next = mem_reg[rp_reg];
            left_next = left_reg - 13'h0001;
            bc_next = 4'h1;
            par_next = 1'b1;
          end
        end else begin
          mod_next = sh_reg[0]; // [R2]
          crc_next = crcStep(crc_reg, sh_reg[0]);
          par_next = par_reg ^ sh_reg[0];
          sh_next = {1'b0, sh_reg[7:1]};
          bc_next = bc_reg + 4'h1;
          if (bc_reg == 4'h8) begin
            bc_next = 4'h0;
            if (txm_reg == rf_frame_codec_pkg::MODE_FRAMED) begin
              ts_next = T_PAR;
            end
          end
        end
      end
      T_PAR: begin
        mod_next = par_reg; // [R1]
        ts_next = T_DATA;
        bc_next = 4'h0;
      end
      T_CRC: begin
        mod_next = crc_reg[bc_reg]; // [R1]
        bc_next = bc_reg + 4'h1;
        if (bc_reg == 4'hF) begin
          ts_next = T_EOF;
        end
      end
      T_EOF: begin
        mod_next = 1'b0; // [R1]
        ts_next = T_IDLE;
      end
    endcase
    unique case (rxm_reg)
      rf_frame_codec_pkg::MODE_TRANSPARENT: begin
        sout_next = rxBit; // [R6]
      end
      rf_frame_codec_pkg::MODE_STREAM: begin
        if (rxBitValid) begin
          rsh_next = {1'b0, rxBit, rsh_reg[7:1]};
          rbc_next = rbc_reg + 4'h1;
          if (rbc_reg == 4'h7) begin
            push = 1'b1; // [R5]
            pushData = {rxBit, rsh_reg[7:1]};
            rbc_next = 4'h0;
          end
        end
      end
      default: begin
        if (rxBitValid) begin
          rin_next = 1'b1;
          if (!rsof_reg) begin
            rsof_next = 1'b1;
            if (!rxBit) begin
              st_next.framingError = 1'b1; // [R4]
            end
            rcrc_next = `CRC_INIT;
            rpar_next = 1'b1;
            rbc_next = 4'h0;
            rlen_next = 10'h000;
          end else begin
            rsh_next = {rxBit, rsh_reg[8:1]};
            rbc_next = rbc_reg + 4'h1;
            if (rbc_reg != 4'h8) begin
              rpar_next = rpar_reg ^ rxBit;
              rcrc_next = crcStep(rcrc_reg, rxBit);
            end else begin
              rbc_next = 4'h0;
              rpar_next = 1'b1;
              if (rpar_reg != rxBit) begin
                st_next.parityError = 1'b1; // [R4]
              end
              // reader rx is unbounded; card emulation stops storing at the limit
              if (cardEmulation && rlen_reg == `CARD_FRAME_MAX) begin
                st_next.lengthError = 1'b1; // [R9]
              end else begin
                push = 1'b1; // [R4]
                pushData = rsh_reg[8:1];
                rlen_next = rlen_reg + 10'h001;
              end
            end
          end
        end
        if (rxFrameEnd && rin_reg) begin
          // crc bytes land in the fifo too; residue zero means crc good
          st_next.crcError = st_reg.crcError || (rcrc_reg != 16'h0000) || (rbc_reg != 4'h0); // [R4]
          st_next.frameDone = 1'b1;
          rin_next = 1'b0;
          rsof_next = 1'b0;
        end
      end
    endcase
    if (push && cnt_reg == (AW+1)'(DEPTH)) begin
      st_next.overflow = 1'b1; // [R7]
    end
    if (txStart && !dirTx) begin
      st_next.crcError = 1'b0;
      st_next.parityError = 1'b0;
      st_next.framingError = 1'b0;
      st_next.overflow = 1'b0;
      st_next.lengthError = 1'b0;
    end
  end

  always_comb begin
    hr_next = '0;
    pop = popTx;
    if (hostReadReq && !dirTx && cnt_reg != '0) begin
      pop = 1'b1; // [R7]
      hr_next.data = mem_reg[rp_reg];
      hr_next.valid = 1'b1;
    end
    rp_next = pop ? rp_reg + AW'(1) : rp_reg;
    wp_next = wp_reg;
    cnt_next = cnt_reg - (pop ? (AW+1)'(1) : '0);
  end

  logic doWrite;
  logic [7:0] wData;
  assign doWrite = (dirTx ? hostWrite.valid : push) && cnt_reg != (AW+1)'(DEPTH);
  assign wData = dirTx ? hostWrite.data : pushData;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ts_reg <= T_IDLE;
      txm_reg <= rf_frame_codec_pkg::MODE_FRAMED;
      rxm_reg <= rf_frame_codec_pkg::MODE_FRAMED;
      sh_reg <= 8'h00;
      bc_reg <= 4'h0;
      left_reg <= 13'h0000;
      crc_reg <= 16'h0000;
      par_reg <= 1'b0;
      mod_reg <= 1'b0;
      rsh_reg <= 9'h000;
      rbc_reg <= 4'h0;
      rlen_reg <= 10'h000;
      rsof_reg <= 1'b0;
      rin_reg <= 1'b0;
      rcrc_reg <= 16'h0000;
      rpar_reg <= 1'b0;
      st_reg <= '0;
      sout_reg <= 1'b0;
      hr_reg <= '0;
      rp_reg <= '0;
      wp_reg <= '0;
      cnt_reg <= '0;
      spi_reg <= 1'b0;
      i2c_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (ts_next != T_IDLE);
      ts_reg <= ts_next;
      txm_reg <= txm_next;
      rxm_reg <= rxm_next;
      sh_reg <= sh_next;
      bc_reg <= bc_next;
      left_reg <= left_next;
      crc_reg <= crc_next;
      par_reg <= par_next;
      mod_reg <= mod_next;
      rsh_reg <= rsh_next;
      rbc_reg <= rbc_next;
      rlen_reg <= rlen_next;
      rsof_reg <= rsof_next;
      rin_reg <= rin_next;
      rcrc_reg <= rcrc_next;
      rpar_reg <= rpar_next;
      st_reg <= st_next;
      sout_reg <= sout_next;
      hr_reg <= hr_next;
      rp_reg <= rp_next;
      wp_reg <= doWrite ? wp_reg + AW'(1) : wp_next; // [R7]
      cnt_reg <= cnt_next + (doWrite ? (AW+1)'(1) : '0);
      spi_reg <= !i2cSelect; // [R10]
      i2c_reg <= i2cSelect; // [R10]
    end
  end

  // storage has no reset so it maps to plain flops without a reset tree
  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem_reg[wp_reg] <= wData;
    end
  end

  assign txMod = mod_reg;
  assign txBusy = busy_reg;
  assign hostSerialOut = sout_reg;
  assign hostRead = hr_reg;
  assign rxStatus = st_reg;
  assign fifoCount = cnt_reg;
  assign spiActive = spi_reg;
  assign i2cActive = i2c_reg;
endmodule

// [bench/rf_frame_codec_fifo_chk.sv]
// Purpose: port checks of the rf frame codec
// Assumes: bound to the codec top
// Notes: bypass checks wait for the mode to settle
`timescale 1ns/100ps
module rf_frame_codec_fifo_chk #(
  parameter int AW = 9
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // controls
  input wire rf_frame_codec_pkg::path_mode_t txMode,
  input wire rf_frame_codec_pkg::path_mode_t rxMode,
  input wire logic dirTx,
  input wire logic i2cSelect,
  input wire logic [12:0] txLength,
  input wire logic txStart,
  input wire rf_frame_codec_pkg::byte_bus_t hostWrite,
  input wire logic hostReadReq,
  input wire logic hostSerialIn,
  input wire logic rxBit,
  // results
  input wire rf_frame_codec_pkg::byte_bus_t hostRead,
  input wire logic hostSerialOut,
  input wire logic spiActive,
  input wire logic i2cActive,
  input wire logic txMod,
  input wire logic txBusy,
  input wire rf_frame_codec_pkg::rx_status_t rxStatus,
  input wire logic [AW:0] fifoCount
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_TX_START: assert property (txStart && dirTx && txLength != 0 && !txBusy &&
    txMode == rf_frame_codec_pkg::MODE_FRAMED |=> txBusy ##1 txMod) else $error("framed tx did not open");
  AST_TRANSP_TX: assert property ($past(arst_n, 2) && txMode == rf_frame_codec_pkg::MODE_TRANSPARENT &&
    $past(txMode) == txMode && $past(txMode, 2) == txMode && !txBusy && !$past(txBusy) && !$past(txBusy, 2)
    |-> txMod == $past(hostSerialIn)) else $error("tx bypass mismatch");
  AST_TRANSP_RX: assert property ($past(arst_n, 2) && rxMode == rf_frame_codec_pkg::MODE_TRANSPARENT &&
    $past(rxMode) == rxMode && $past(rxMode, 2) == rxMode |-> hostSerialOut == $past(rxBit))
    else $error("rx bypass mismatch");
  AST_SEL: assert property ($past(arst_n) |-> i2cActive == $past(i2cSelect) && spiActive != i2cActive)
    else $error("port select mismatch");
  AST_FIFO_INC: assert property (hostWrite.valid && dirTx && !txBusy && fifoCount < (1 << AW) |=>
    fifoCount == $past(fifoCount) + 1'b1) else $error("fifo write not counted");
  AST_READ: assert property (hostReadReq && !dirTx && fifoCount != 0 |=> hostRead.valid)
    else $error("fifo read gave no data");
  AST_DONE_PULSE: assert property (rxStatus.frameDone |=> !rxStatus.frameDone)
    else $error("frame done not a pulse");
  AST_STICKY: assert property (rxStatus.crcError && !(txStart && !dirTx) |=> rxStatus.crcError)
    else $error("crc error flag lost");
endmodule
bind rf_frame_codec_fifo rf_frame_codec_fifo_chk #(.AW(AW)) u_rf_frame_codec_fifo_chk (.*);

// [bench/rf_air_model.sv]
// Purpose: air side model feeding the codec receive path
// Assumes: one bit per clock while valid
// Notes: a released data line shows the inverse of its last level
`timescale 1ns/100ps
module rf_air_model (
  // clock
  input wire logic sys_clk,
  // receive bit stream
  output logic rxBit,
  output logic rxBitValid,
  output logic rxFrameEnd
);
  logic [7:0] q[$];
  initial begin
    rxBit = 1'b0;
    rxBitValid = 1'b0;
    rxFrameEnd = 1'b0;
  end
  task automatic put(input logic b);
    @(posedge sys_clk);
    rxBit <= b;
    rxBitValid <= 1'b1;
  endtask
  // stale level must not pass for data once released
  task automatic idle(input logic fin);
    @(posedge sys_clk);
    rxBit <= ~rxBit;
    rxBitValid <= 1'b0;
    rxFrameEnd <= fin;
    @(posedge sys_clk);
    rxFrameEnd <= 1'b0;
  endtask
  // short frames only, well under the card emulation cap
  task automatic send(input logic framed, input logic bad);
    logic [15:0] c;
    c = 16'h6363;
    foreach (q[i])
      for (int b = 0; b < 8; b++)
        c = {1'b0, c[15:1]} ^ ((c[0] ^ q[i][b]) ? 16'h8408 : 16'h0000);
    if (framed) begin
      q.push_back(c[7:0] ^ {7'h00, bad});
      q.push_back(c[15:8]);
      put(1'b1);
    end
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++)
        put(q[i][b]);
      if (framed)
        put(~^q[i]);
    end
    idle(framed);
    q = {};
  endtask
endmodule

// [bench/rf_frame_codec_fifo_bench.sv]
// Purpose: self-checking bench of the rf frame codec
// Assumes: inputs change by nonblocking assignment at the rising edge
// Notes: a fresh reset precedes the bypass table, framed rx, stream rx and fill scenarios only
`timescale 1ns/100ps
module rf_frame_codec_fifo_bench;
  logic sys_clk, arst_n, cardEmulation, dirTx, i2cSelect, txStart, hostReadReq, hostSerialIn;
  logic hostSerialOut, spiActive, i2cActive, rxBit, rxBitValid, rxFrameEnd, txMod, txBusy;
  logic [12:0] txLength;
  logic [9:0] fifoCount;
  rf_frame_codec_pkg::path_mode_t txMode, rxMode;
  rf_frame_codec_pkg::byte_bus_t hostWrite, hostRead;
  rf_frame_codec_pkg::rx_status_t rxStatus;
  int n_fail, checks;
  logic e[$];
  // select, serial in, air bit; then expected i2cActive, txMod, hostSerialOut
  logic [5:0] rows[4] = '{6'h00, 6'h3F, 6'h2D, 6'h12};
  rf_frame_codec_fifo u_rf_frame_codec_fifo (.*);
  rf_air_model u_rf_air_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rst;
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk);
    hostWrite <= {d, 1'b1};
    @(posedge sys_clk);
    hostWrite <= '0;
  endtask
  task automatic rd(input logic [7:0] d);
    @(posedge sys_clk);
    hostReadReq <= 1'b1;
    @(posedge sys_clk);
    hostReadReq <= 1'b0;
    #1 cmp("hostRead", {7'h00, d, 1'b1}, 16'(hostRead));
  endtask
  task automatic send_tx(input logic [7:0] d[$], input logic framed);
    logic [15:0] c;
    c = 16'h6363;
    e = {};
    @(posedge sys_clk);
    dirTx <= 1'b1;
    txMode <= framed ? rf_frame_codec_pkg::MODE_FRAMED : rf_frame_codec_pkg::MODE_STREAM;
    if (framed) e = {1'b1, 1'b1};
    foreach (d[i]) begin
      wr(d[i]);
      e.push_back(1'b0);
      for (int b = 0; b < 8; b++) begin
        e.push_back(d[i][b]);
        c = {1'b0, c[15:1]} ^ ((c[0] ^ d[i][b]) ? 16'h8408 : 16'h0000);
      end
      if (framed) e.push_back(~^d[i]);
    end
    // the empty load slot that finds no bytes left precedes the crc
    if (framed) e.push_back(1'b0);
    for (int b = 0; b < 16 && framed; b++) e.push_back(c[b]);
    if (framed) e.push_back(1'b0);
    @(posedge sys_clk);
    txLength <= 13'(d.size());
    txStart <= 1'b1;
    @(posedge sys_clk);
    txStart <= 1'b0;
    // mode change in mid-frame must wait for the frame end
    txMode <= rf_frame_codec_pkg::MODE_TRANSPARENT;
    foreach (e[i]) begin
      @(posedge sys_clk);
      #1 cmp("txMod", {15'h0000, e[i]}, {15'h0000, txMod});
    end
    repeat (3) @(posedge sys_clk);
    #1 cmp("fifoCount", 16'h0000, 16'(fifoCount));
    cmp("txBusy", 16'h0000, {15'h0000, txBusy});
  endtask
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    conclude;
  end
  initial begin
    {arst_n, cardEmulation, dirTx, i2cSelect, txStart, hostReadReq, hostSerialIn} = '0;
    txMode = rf_frame_codec_pkg::MODE_FRAMED;
    rxMode = rf_frame_codec_pkg::MODE_FRAMED;
    txLength = '0;
    hostWrite = '0;
    n_fail = 0;
    checks = 0;
    rst;
    @(posedge sys_clk);
    txMode <= rf_frame_codec_pkg::MODE_TRANSPARENT;
    rxMode <= rf_frame_codec_pkg::MODE_TRANSPARENT;
    #1 cmp("fifoCount", 16'h0000, 16'(fifoCount));
    foreach (rows[i]) begin
      u_rf_air_model.put(rows[i][3]);
      i2cSelect <= rows[i][5];
      hostSerialIn <= rows[i][4];
      repeat (3) @(posedge sys_clk);
      #1 cmp("bypass", {13'h0000, rows[i][2:0]}, {13'h0000, i2cActive, txMod, hostSerialOut});
    end
    u_rf_air_model.idle(1'b0);
    $display("test table done");
    send_tx({8'hA5, 8'h01}, 1'b1);
    send_tx({8'h3C}, 1'b0);
    $display("test tx done");
    rst;
    @(posedge sys_clk);
    dirTx <= 1'b0;
    rxMode <= rf_frame_codec_pkg::MODE_FRAMED;
    u_rf_air_model.q = {8'h12, 8'h34};
    u_rf_air_model.send(1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1 cmp("fifoCount", 16'h0004, 16'(fifoCount));
    cmp("crcError", 16'h0000, {15'h0000, rxStatus.crcError});
    rd(8'h12);
    rd(8'h34);
    u_rf_air_model.q = {8'hC3};
    u_rf_air_model.send(1'b1, 1'b1);
    repeat (2) @(posedge sys_clk);
    #1 cmp("crcError", 16'h0001, {15'h0000, rxStatus.crcError});
    @(posedge sys_clk);
    txStart <= 1'b1;
    @(posedge sys_clk);
    txStart <= 1'b0;
    #1 cmp("crcError", 16'h0000, {15'h0000, rxStatus.crcError});
    rst;
    @(posedge sys_clk);
    rxMode <= rf_frame_codec_pkg::MODE_STREAM;
    u_rf_air_model.q = {8'h5A};
    u_rf_air_model.send(1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1 cmp("fifoCount", 16'h0001, 16'(fifoCount));
    rd(8'h5A);
    $display("test rx done");
    rst;
    @(posedge sys_clk);
    dirTx <= 1'b1;
    repeat (513) wr(8'hFF);
    #1 cmp("fifoCount", 16'h0200, 16'(fifoCount));
    $display("test fill done");
    conclude;
  end
endmodule
